// File: sfsp_pkg.sv
package sfsp_pkg;
    localparam int CLK_PERIOD_NS = 5;
    localparam int UNLOCK_SETTLE_NS = 2000;
    localparam int UNLOCK_RETRY_NS = 100000;
    localparam int UNLOCK_SETTLE_CYC = (UNLOCK_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int UNLOCK_RETRY_CYC = (UNLOCK_RETRY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TIMER_W = 24;
    localparam int SECTOR_LSB = 16;

    localparam logic [7:0] OP_WRITE_EN = 8'h06;
    localparam logic [7:0] OP_WRITE_DIS = 8'h04;
    localparam logic [7:0] OP_RESET_EN = 8'h66;
    localparam logic [7:0] OP_RESET = 8'h99;
    localparam logic [7:0] OP_RD_STATUS = 8'h05;
    localparam logic [7:0] OP_RD_SECURITY = 8'h2b;
    localparam logic [7:0] OP_SELECT = 8'h68;
    localparam logic [7:0] OP_GANG_LOCK = 8'h7e;
    localparam logic [7:0] OP_GANG_UNLOCK = 8'h98;
    localparam logic [7:0] OP_LOCK_WR = 8'h2c;
    localparam logic [7:0] OP_LOCK_RD = 8'h2d;
    localparam logic [7:0] OP_PASS_RD = 8'h27;
    localparam logic [7:0] OP_PASS_PGM = 8'h28;
    localparam logic [7:0] OP_PASS_UNLOCK = 8'h29;
    localparam logic [7:0] OP_SOLID_RD = 8'he2;
    localparam logic [7:0] OP_SOLID_PGM = 8'he3;
    localparam logic [7:0] OP_SOLID_ERASE = 8'he4;
    localparam logic [7:0] OP_SLOCK_SET = 8'ha6;
    localparam logic [7:0] OP_SLOCK_RD = 8'ha7;
    localparam logic [7:0] OP_DYN_RD = 8'he0;
    localparam logic [7:0] OP_DYN_WR = 8'he1;
    localparam logic [7:0] OP_TEMP_WR = 8'hc5;
    localparam logic [7:0] OP_TEMP_RD = 8'hc6;

    localparam logic [3:0] LEN_OPCODE = 4'h1;
    localparam logic [3:0] LEN_TEMP_WR = 4'h2;
    localparam logic [3:0] LEN_LOCK_WR = 4'h3;
    localparam logic [3:0] LEN_SECTOR = 4'h5;
    localparam logic [3:0] LEN_DYN_WR = 4'h6;
    localparam logic [3:0] LEN_PASSWORD = 4'h9;

    localparam logic [7:0] BYTE_CLEAR = 8'h00;
    localparam logic [7:0] BYTE_SET = 8'hff;
    localparam logic [15:0] LOCK_REG_RST = 16'hffff;
    localparam int LOCK_SOLID_BIT = 1;
    localparam int LOCK_PASS_BIT = 2;
    localparam logic [63:0] PASSWORD_RST = 64'hffff_ffff_ffff_ffff;

    typedef enum logic [1:0] {
        BZ_IDLE = 2'b00,
        BZ_WRITE = 2'b01,
        BZ_PASS_OK = 2'b10,
        BZ_PASS_BAD = 2'b11
    } sfsp_busy_e;
endpackage

// File: sfsp_timer_if.sv
`timescale 1ns/1ps
interface sfsp_timer_if;
    logic start;
    logic [sfsp_pkg::TIMER_W-1:0] cycles;
    logic done;
    modport ctrl (output start, output cycles, input done);
    modport timer (input start, input cycles, output done);
endinterface

// File: sfsp_pin_sync.sv
`timescale 1ns/1ps
module sfsp_pin_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
)(
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    // pins and filtered levels
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] level_out
);
    typedef struct packed {
        logic [W-1:0] q1;
        logic [W-1:0] q2;
        logic [W-1:0] q3;
        logic [W-1:0] level;
    } sfsp_sync_s;

    sfsp_sync_s st;
    sfsp_sync_s next_st;

    always_comb begin
        next_st = st;
        next_st.q1 = pin_in;
        next_st.q2 = st.q1;
        next_st.q3 = st.q2;
        // level follows only when stages two and three agree
        next_st.level = (st.q3 & ~(st.q2 ^ st.q3)) | (st.level & (st.q2 ^ st.q3));
    end

    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            st <= {4{RST_VAL}};
        end else begin
            st <= next_st;
        end
    end

    assign level_out = st.level;
endmodule

// File: sfsp_delay_timer.sv
`timescale 1ns/1ps
module sfsp_delay_timer (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    // control
    sfsp_timer_if.timer tmr
);
    import sfsp_pkg::*;

    typedef struct packed {
        logic run;
        logic [TIMER_W-1:0] cnt;
        logic done;
    } sfsp_timer_s;

    sfsp_timer_s st;
    sfsp_timer_s next_st;

    always_comb begin
        next_st = st;
        next_st.done = 1'b0;
        if (tmr.start) begin
            next_st.run = 1'b1;
            next_st.cnt = tmr.cycles;
        end else if (st.run) begin
            if (st.cnt <= TIMER_W'(1)) begin
                next_st.run = 1'b0;
                next_st.done = 1'b1;
            end else begin
                next_st.cnt = st.cnt - TIMER_W'(1);
            end
        end
    end

    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign tmr.done = st.done;
endmodule

// File: sfsp_sector_protect.sv
`timescale 1ns/1ps
module sfsp_sector_protect #(
    parameter int SECTORS = 256,
    parameter int SEC_W = $clog2(SECTORS),
    parameter int UNLOCK_RETRY_CYCLES = sfsp_pkg::UNLOCK_RETRY_CYC,
    parameter int SOLID_PGM_CYCLES = 200,
    parameter int SOLID_ERASE_CYCLES = 400
)(
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    // serial link
    input wire logic cs_n_in,
    input wire logic sclk_in,
    input wire logic quad_line_mode_in,
    input wire logic [3:0] sio_in,
    output logic [3:0] sio_out,
    output logic [3:0] sio_oe_n_out,
    // status
    output logic write_in_progress_out,
    // array write gate
    input wire logic arr_req_in,
    input wire logic [SEC_W-1:0] arr_sector_in,
    input wire logic bp_protect_in,
    output logic arr_grant_out,
    output logic arr_reject_out
);
    import sfsp_pkg::*;

    localparam int SEC_AT_HDR = 8 + SECTOR_LSB;
    localparam int SEC_AT_DYN = 16 + SECTOR_LSB;

    typedef struct packed {
        sfsp_busy_e busy;
        logic tmr_go;
        logic [TIMER_W-1:0] tmr_cyc;
        logic [7:0] pend_op;
        logic [SEC_W-1:0] pend_sec;
        logic [63:0] pend_data;
        logic sclk_q;
        logic cs_q;
        logic [2:0] bit_cnt;
        logic [3:0] byte_cnt;
        logic [7:0] in_sr;
        logic [7:0] opcode;
        logic [63:0] data;
        logic out_act;
        logic [7:0] out_sr;
        logic [2:0] out_bits;
        logic [2:0] out_byte;
        logic [SEC_W-1:0] rd_sec;
        logic [3:0] dout;
        logic [3:0] doe_n;
        logic wel;
        logic rst_armed;
        logic p_fail;
        logic sel;
        logic [15:0] lock_reg;
        logic solid_lock;
        logic temp_unprot;
        logic [63:0] password;
        logic [SECTORS-1:0] solid;
        logic [SECTORS-1:0] dyn;
    } sfsp_state_s;

    sfsp_state_s st;
    sfsp_state_s next_st;

    logic cs_s;
    logic sclk_s;
    logic [3:0] sio_s;
    logic sclk_rise;
    logic sclk_fall;
    logic cs_rise;
    logic pass_mode;
    logic sec_prot;

    sfsp_timer_if tmr();

    sfsp_pin_sync #(.W(2), .RST_VAL(2'b10)) u_ctrl_sync (
        .ref_clk_in(ref_clk_in),
        .sys_rst_in(sys_rst_in),
        .pin_in({cs_n_in, sclk_in}),
        .level_out({cs_s, sclk_s})
    );

    sfsp_pin_sync #(.W(4), .RST_VAL(4'h0)) u_data_sync (
        .ref_clk_in(ref_clk_in),
        .sys_rst_in(sys_rst_in),
        .pin_in(sio_in),
        .level_out(sio_s)
    );

    sfsp_delay_timer u_timer (
        .ref_clk_in(ref_clk_in),
        .sys_rst_in(sys_rst_in),
        .tmr(tmr.timer)
    );

    assign tmr.start = st.tmr_go;
    assign tmr.cycles = st.tmr_cyc;

    assign sclk_rise = sclk_s & ~st.sclk_q;
    assign sclk_fall = ~sclk_s & st.sclk_q;
    assign cs_rise = cs_s & ~st.cs_q;
    assign pass_mode = ~st.lock_reg[LOCK_PASS_BIT];

    // bytes that must sit in front of read data
    function automatic logic [3:0] hdr_len(input logic [7:0] op);
        unique case (op)
            OP_SOLID_RD, OP_DYN_RD: hdr_len = LEN_SECTOR;
            OP_RD_STATUS, OP_RD_SECURITY, OP_LOCK_RD, OP_PASS_RD,
            OP_SLOCK_RD, OP_TEMP_RD: hdr_len = LEN_OPCODE;
            default: hdr_len = 4'h0;
        endcase
    endfunction

    // exact frame length of each executing command
    function automatic logic [3:0] cmd_len(input logic [7:0] op);
        unique case (op)
            OP_SOLID_PGM: cmd_len = LEN_SECTOR;
            OP_DYN_WR: cmd_len = LEN_DYN_WR;
            OP_TEMP_WR: cmd_len = LEN_TEMP_WR;
            OP_LOCK_WR: cmd_len = LEN_LOCK_WR;
            OP_PASS_PGM, OP_PASS_UNLOCK: cmd_len = LEN_PASSWORD;
            OP_WRITE_EN, OP_WRITE_DIS, OP_RESET_EN, OP_RESET, OP_SELECT,
            OP_GANG_LOCK, OP_GANG_UNLOCK, OP_SOLID_ERASE, OP_SLOCK_SET: cmd_len = LEN_OPCODE;
            default: cmd_len = 4'h0;
        endcase
    endfunction

    function automatic logic [7:0] read_value(input logic [7:0] op, input logic [SEC_W-1:0] sec,
                                              input logic [2:0] idx);
        unique case (op)
            OP_RD_STATUS: read_value = {6'h00, st.wel, st.busy != BZ_IDLE};
            OP_RD_SECURITY: read_value = {st.sel, 1'b0, st.p_fail, 5'h00};
            OP_LOCK_RD: read_value = idx[0] ? st.lock_reg[15:8] : st.lock_reg[7:0];
            OP_SLOCK_RD: read_value = {7'h00, st.solid_lock};
            OP_TEMP_RD: read_value = {7'h00, st.temp_unprot};
            OP_SOLID_RD: read_value = st.solid[sec] ? BYTE_SET : BYTE_CLEAR;
            OP_DYN_RD: read_value = st.dyn[sec] ? BYTE_SET : BYTE_CLEAR;
            OP_PASS_RD: read_value = pass_mode ? BYTE_SET : st.password[{idx, 3'b000} +: 8];
            default: read_value = BYTE_CLEAR;
        endcase
    endfunction

    always_comb begin
        logic [7:0] byte_v;
        logic [SEC_W-1:0] sec_v;
        byte_v = 8'h00;
        sec_v = st.data[SEC_AT_HDR +: SEC_W];
        next_st = st;
        next_st.tmr_go = 1'b0;
        next_st.sclk_q = sclk_s;
        next_st.cs_q = cs_s;

        // end of a timed operation
        if (tmr.done && st.busy != BZ_IDLE) begin
            next_st.busy = BZ_IDLE;
            unique case (st.busy)
                BZ_WRITE: begin
                    unique case (st.pend_op)
                        OP_SOLID_PGM: begin
                            if (st.solid_lock) begin
                                next_st.solid[st.pend_sec] = 1'b1;
                            end else begin
                                next_st.p_fail = 1'b1;
                            end
                        end
                        OP_SOLID_ERASE: begin
                            if (st.solid_lock) begin
                                next_st.solid = '0;
                            end else begin
                                next_st.p_fail = 1'b1;
                            end
                        end
                        OP_LOCK_WR: begin
                            if (!st.pend_data[8 + LOCK_SOLID_BIT] && !st.pend_data[8 + LOCK_PASS_BIT]) begin
                                next_st.p_fail = 1'b1;
                            end else if (!st.lock_reg[LOCK_SOLID_BIT] || !st.lock_reg[LOCK_PASS_BIT]) begin
                                next_st.p_fail = 1'b1;
                            end else begin
                                next_st.lock_reg = st.lock_reg & {st.pend_data[7:0], st.pend_data[15:8]};
                            end
                        end
                        OP_PASS_PGM: next_st.password = st.password & st.pend_data;
                        default: next_st.p_fail = st.p_fail;
                    endcase
                end
                BZ_PASS_OK: next_st.solid_lock = 1'b1;
                BZ_PASS_BAD: next_st.p_fail = 1'b1;
                BZ_IDLE: next_st.busy = BZ_IDLE;
            endcase
        end

        // command capture
        if (!cs_s && sclk_rise && !st.out_act) begin
            if (quad_line_mode_in) begin
                byte_v = {st.in_sr[3:0], sio_s};
                next_st.bit_cnt = st.bit_cnt + 3'd4;
            end else begin
                byte_v = {st.in_sr[6:0], sio_s[0]};
                next_st.bit_cnt = st.bit_cnt + 3'd1;
            end
            next_st.in_sr = byte_v;
            if (next_st.bit_cnt == 3'd0) begin
                if (st.byte_cnt != 4'hf) begin
                    next_st.byte_cnt = st.byte_cnt + 4'h1;
                end
                if (st.byte_cnt == 4'h0) begin
                    next_st.opcode = byte_v;
                end else begin
                    next_st.data = {st.data[55:0], byte_v};
                end
                if (hdr_len(next_st.opcode) != 4'h0 && hdr_len(next_st.opcode) == next_st.byte_cnt) begin
                    sec_v = next_st.data[SEC_AT_HDR +: SEC_W];
                    next_st.out_act = 1'b1;
                    next_st.out_byte = 3'd0;
                    next_st.out_bits = 3'd0;
                    next_st.rd_sec = sec_v;
                    next_st.out_sr = read_value(next_st.opcode, sec_v, 3'd0);
                end
            end
        end

        // read data leaves on the falling clock
        if (!cs_s && sclk_fall && st.out_act) begin
            if (quad_line_mode_in) begin
                next_st.dout = st.out_sr[7:4];
                next_st.doe_n = 4'b0000;
                next_st.out_sr = {st.out_sr[3:0], 4'h0};
                next_st.out_bits = st.out_bits + 3'd4;
            end else begin
                next_st.dout = {2'b00, st.out_sr[7], 1'b0};
                next_st.doe_n = 4'b1101;
                next_st.out_sr = {st.out_sr[6:0], 1'b0};
                next_st.out_bits = st.out_bits + 3'd1;
            end
            if (next_st.out_bits == 3'd0) begin
                next_st.out_byte = st.out_byte + 3'd1;
                next_st.out_sr = read_value(st.opcode, st.rd_sec, st.out_byte + 3'd1);
            end
        end

        // execution at the end of the frame
        if (cs_rise) begin
            next_st.bit_cnt = 3'd0;
            next_st.byte_cnt = 4'h0;
            next_st.out_act = 1'b0;
            next_st.doe_n = 4'b1111;
            next_st.dout = 4'h0;
            if (st.bit_cnt == 3'd0 && st.byte_cnt == cmd_len(st.opcode) && st.byte_cnt != 4'h0 &&
                (st.busy == BZ_IDLE || st.opcode == OP_RESET_EN || st.opcode == OP_RESET)) begin
                next_st.rst_armed = 1'b0;
                unique case (st.opcode)
                    OP_WRITE_EN: next_st.wel = 1'b1;
                    OP_WRITE_DIS: next_st.wel = 1'b0;
                    OP_RESET_EN: next_st.rst_armed = 1'b1;
                    OP_RESET: begin
                        if (st.rst_armed) begin
                            next_st.busy = BZ_IDLE;
                            next_st.dyn = '1;
                            next_st.temp_unprot = 1'b1;
                            next_st.solid_lock = st.lock_reg[LOCK_PASS_BIT];
                            next_st.wel = 1'b0;
                            next_st.p_fail = 1'b0;
                        end
                    end
                    OP_SELECT: begin
                        if (st.wel) begin
                            next_st.sel = 1'b1;
                            next_st.dyn = '1;
                            next_st.wel = 1'b0;
                        end
                    end
                    OP_GANG_LOCK: begin
                        if (st.wel && st.sel) begin
                            next_st.dyn = '1;
                            next_st.wel = 1'b0;
                        end
                    end
                    OP_GANG_UNLOCK: begin
                        if (st.wel && st.sel) begin
                            next_st.dyn = '0;
                            next_st.wel = 1'b0;
                        end
                    end
                    OP_TEMP_WR: begin
                        if (st.sel) begin
                            next_st.temp_unprot = st.data[0];
                        end
                    end
                    OP_DYN_WR: begin
                        if (st.sel && st.wel) begin
                            next_st.dyn[st.data[SEC_AT_DYN +: SEC_W]] = st.data[7:0] != BYTE_CLEAR;
                            next_st.wel = 1'b0;
                        end
                    end
                    OP_SLOCK_SET: begin
                        if (st.sel && st.wel) begin
                            next_st.solid_lock = 1'b0;
                            next_st.wel = 1'b0;
                        end
                    end
                    OP_SOLID_PGM, OP_SOLID_ERASE, OP_LOCK_WR, OP_PASS_PGM: begin
                        if (st.wel && (st.sel || st.opcode == OP_LOCK_WR || st.opcode == OP_PASS_PGM) &&
                            !(pass_mode && st.opcode == OP_PASS_PGM)) begin
                            next_st.busy = BZ_WRITE;
                            next_st.pend_op = st.opcode;
                            next_st.pend_sec = sec_v;
                            next_st.pend_data = st.data;
                            next_st.p_fail = 1'b0;
                            next_st.wel = 1'b0;
                            next_st.tmr_go = 1'b1;
                            next_st.tmr_cyc = (st.opcode == OP_SOLID_ERASE) ? TIMER_W'(SOLID_ERASE_CYCLES)
                                                                            : TIMER_W'(SOLID_PGM_CYCLES);
                        end
                    end
                    OP_PASS_UNLOCK: begin
                        if (pass_mode) begin
                            next_st.tmr_go = 1'b1;
                            if (st.data == st.password) begin
                                next_st.busy = BZ_PASS_OK;
                                next_st.tmr_cyc = TIMER_W'(UNLOCK_SETTLE_CYC);
                            end else begin
                                next_st.busy = BZ_PASS_BAD;
                                next_st.p_fail = 1'b1;
                                next_st.tmr_cyc = TIMER_W'(UNLOCK_RETRY_CYCLES);
                            end
                        end
                    end
                    default: next_st.rst_armed = 1'b0;
                endcase
            end else if (st.byte_cnt != 4'h0) begin
                next_st.rst_armed = 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            st <= '0;
            st.cs_q <= 1'b1;
            st.doe_n <= 4'b1111;
            st.lock_reg <= LOCK_REG_RST;
            st.solid_lock <= 1'b1;
            st.temp_unprot <= 1'b1;
            st.password <= PASSWORD_RST;
            st.dyn <= '1;
        end else begin
            st <= next_st;
        end
    end

    // sector resolution for the array
    assign sec_prot = st.dyn[arr_sector_in] | (st.solid[arr_sector_in] & st.temp_unprot);
    assign arr_reject_out = arr_req_in & (st.sel ? sec_prot : bp_protect_in);
    assign arr_grant_out = arr_req_in & ~(st.sel ? sec_prot : bp_protect_in);

    assign sio_out = st.dout;
    assign sio_oe_n_out = st.doe_n;
    assign write_in_progress_out = st.busy != BZ_IDLE;
endmodule

// File: sfsp_sector_protect_props.sv
`timescale 1ns/1ps
module sfsp_sector_protect_props (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    // watched ports
    input wire logic cs_n_in,
    input wire logic [3:0] sio_oe_n_out,
    input wire logic write_in_progress_out,
    input wire logic arr_req_in,
    input wire logic arr_grant_out,
    input wire logic arr_reject_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (sys_rst_in);
    a_grant_needs_req: assert property (arr_grant_out |-> arr_req_in) else $error("stray grant");
    a_reject_needs_req: assert property (arr_reject_out |-> arr_req_in) else $error("stray reject");
    a_gate_one_hot: assert property (arr_req_in |-> arr_grant_out ^ arr_reject_out) else $error("gate");
    a_oe_code: assert property (sio_oe_n_out inside {4'hf, 4'hd, 4'h0}) else $error("oe code");
    a_oe_idle: assert property (cs_n_in [*8] |-> sio_oe_n_out == 4'hf) else $error("oe idle");
    a_oe_release: assert property ($rose(cs_n_in) |-> ##[1:8] sio_oe_n_out == 4'hf) else $error("oe hold");
    a_busy_after_cs: assert property ($rose(write_in_progress_out) |-> $past(cs_n_in, 4)) else $error("busy");
    a_reset_quiet: assert property ($fell(sys_rst_in) |-> !write_in_progress_out && sio_oe_n_out == 4'hf)
        else $error("reset state");
    c_grant: cover property (arr_grant_out);
    c_reject: cover property (arr_reject_out);
    c_busy: cover property ($rose(write_in_progress_out));
endmodule
bind sfsp_sector_protect sfsp_sector_protect_props props_u (.*);

// File: sfsp_host.sv
`timescale 1ns/1ps
module sfsp_host (
    // link pins
    output logic cs_n = 1'h1,
    output logic sclk = 1'h0,
    output logic [3:0] sio = 4'h5,
    // wire levels and mode
    input wire logic [3:0] pins,
    input wire logic quad
);
    task automatic tick(input logic [3:0] v, inout logic [7:0] rd);
        sio = v;
        #32 sclk = 1'h1;
        rd = {rd[6:0], pins[1]};
        #32 sclk = 1'h0;
    endtask
    task automatic frame(input logic [7:0] q[$], input int x, output logic [7:0] rd);
        #64 cs_n = 1'h0;
        #64;
        foreach (q[i]) for (int b = 7; b >= 0; b -= quad ? 4 : 1) tick(quad ? q[i][b -: 4] : {{3{~q[i][b]}}, q[i][b]}, rd);
        repeat (x) tick(~sio, rd);
        #32 cs_n = 1'h1;
        #100;
    endtask
endmodule

// File: sfsp_sector_protect_test.sv
`timescale 1ns/1ps
module sfsp_sector_protect_test;
    import sfsp_pkg::*;
    logic ref_clk_in = 1'h0, sys_rst_in = 1'h1, quad = 1'h0, req = 1'h1, bp = 1'h0, p, cs_n, sclk, grant, reject, write_in_progress;
    logic [7:0] sec = 8'h00, rd;
    logic [3:0] hsio, so, oe_n, sio_w;
    int n_fail = 0, samples_checked = 0, cyc = 0, s = 255, temp = 1, sel = 0, dyn[256] = '{default: 1}, sol[256];
    int unsigned xs = 8;
    always #2.5 ref_clk_in = ~ref_clk_in;
    assign sio_w = (oe_n & hsio) | (~oe_n & so);
    sfsp_host host_u (.cs_n(cs_n), .sclk(sclk), .sio(hsio), .pins(sio_w), .quad(quad));
    sfsp_sector_protect #(.UNLOCK_RETRY_CYCLES(50)) dut_u (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
        .cs_n_in(cs_n), .sclk_in(sclk), .quad_line_mode_in(quad), .sio_in(sio_w), .sio_out(so),
        .sio_oe_n_out(oe_n), .write_in_progress_out(write_in_progress), .arr_req_in(req), .arr_sector_in(sec),
        .bp_protect_in(bp), .arr_grant_out(grant), .arr_reject_out(reject));
    function automatic int unsigned rnd();
        xs ^= xs << 13;
        xs ^= xs >> 17;
        xs ^= xs << 5;
        return xs;
    endfunction
    task automatic check(input string n, input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        n_fail += int'(g !== e);
        if (g !== e) $display("BAD %s expected %h seen %h", n, e, g);
    endtask
    task automatic complete_run();
        if (n_fail == 0 && samples_checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic gate(input int g);
        @(negedge ref_clk_in);
        sec = 8'(g);
        bp = 1'(rnd());
        p = sel ? (dyn[g] | (sol[g] & temp)) != 0 : bp;
        #1;
        check("gate", {6'h0, p, !p}, {6'h0, reject, grant});
    endtask
    task automatic tx(input logic [7:0] q[$], input int we = 1, input int x = 0, input int bz = 0);
        if (we != 0) host_u.frame('{OP_WRITE_EN}, 0, rd);
        host_u.frame(q, x, rd);
        check("busy", 8'(bz), {7'h0, write_in_progress});
        wait (write_in_progress === 1'h0);
        gate(s);
        gate(rnd() % 256);
    endtask
    always @(posedge ref_clk_in) begin
        if (++cyc == 60000) begin
            n_fail++;
            complete_run();
        end
    end
    initial begin
        #30 sys_rst_in = 1'h0;
        tx('{OP_GANG_UNLOCK});
        tx('{OP_DYN_RD, 8'hff, 8'h00, 8'h00, 8'h00}, 0, 8);
        check("dynamic", 8'hff, rd);
        sel = 1;
        tx('{OP_SELECT});
        tx('{OP_GANG_UNLOCK}, 0);
        tx('{OP_GANG_UNLOCK}, 1, 3);
        dyn = '{default: 0};
        tx('{OP_GANG_UNLOCK});
        sol[s] = 1;
        tx('{OP_SOLID_PGM, 8'hff, 8'h00, 8'h00, 8'h00}, 1, 0, 1);
        tx('{OP_SLOCK_SET});
        tx('{OP_SOLID_ERASE}, 1, 0, 1);
        tx('{OP_SOLID_RD, 8'hff, 8'h00, 8'h00, 8'h00}, 0, 8);
        check("solid", 8'hff, rd);
        temp = 0;
        tx('{OP_TEMP_WR, 8'h00}, 0);
        dyn[s] = 1;
        tx('{OP_DYN_WR, 8'hff, 8'h00, 8'h00, 8'h00, 8'hff});
        tx('{OP_DYN_RD, 8'hff, 8'h00, 8'h00, 8'h00}, 0, 8);
        check("dynamic", 8'hff, rd);
        tx('{OP_PASS_PGM, 8'h12, 8'h34, 8'h56, 8'h78, 8'h9a, 8'hbc, 8'hde, 8'hf0}, 1, 0, 1);
        tx('{OP_PASS_RD}, 0, 8);
        check("password", 8'hf0, rd);
        tx('{OP_LOCK_WR, 8'hf9, 8'hff}, 1, 0, 1);
        tx('{OP_RD_SECURITY}, 0, 8);
        check("fail flag", 8'ha0, rd);
        tx('{OP_LOCK_WR, 8'hfb, 8'hff}, 1, 0, 1);
        tx('{OP_PASS_RD}, 0, 8);
        check("password", 8'hff, rd);
        tx('{OP_RESET_EN}, 0);
        dyn = '{default: 1};
        temp = 1;
        tx('{OP_RESET}, 0);
        tx('{OP_SLOCK_RD}, 0, 8);
        check("lock", 8'h00, rd);
        tx('{OP_PASS_UNLOCK, 8'h12, 8'h34, 8'h56, 8'h78, 8'h9a, 8'hbc, 8'hde, 8'hf1}, 0, 0, 1);
        tx('{OP_RD_SECURITY}, 0, 8);
        check("fail flag", 8'ha0, rd);
        tx('{OP_PASS_UNLOCK, 8'h12, 8'h34, 8'h56, 8'h78, 8'h9a, 8'hbc, 8'hde, 8'hf0}, 0, 0, 1);
        tx('{OP_SLOCK_RD}, 0, 8);
        check("lock", 8'h01, rd);
        sol = '{default: 0};
        tx('{OP_SOLID_ERASE}, 1, 0, 1);
        quad = 1'h1;
        dyn = '{default: 0};
        tx('{OP_GANG_UNLOCK});
        dyn = '{default: 1};
        tx('{OP_GANG_LOCK});
        complete_run();
    end
endmodule
